// file: logic/rsc_pkg.sv
// Purpose: Shared constants and types of the rail sequence controller.
// Assumes: 25 MHz system clock, registers reached over APB with 32-bit data.
// Notes:   Slot tables hold one 3-bit slot per rail, rail 1 in the low field.
package rsc_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int SLOT_TIME_NS  = 625000;
    localparam int SLOT_CYC      = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_FAULT_FLAGS_A = 8'h00;
    localparam logic [7:0] OFS_FAULT_MASK    = 8'h04;
    localparam logic [7:0] OFS_STATUS        = 8'h08;
    localparam logic [7:0] OFS_CONTROL       = 8'h0c;

    localparam int FLG_EXT_RESET = 0;
    localparam int FLG_EMERGENCY = 1;
    localparam int FLG_SEQ_ABORT = 2;

    localparam int STS_STATE_LSB = 0;
    localparam int STS_SLOT_LSB  = 4;
    localparam int STS_RAILS_LSB = 8;
    localparam int STS_DRIVE_BIT = 16;
    localparam int CTL_SLEEP_EN  = 0;

    localparam logic [2:0]  RST_MASK     = 3'h7;
    localparam logic        RST_SLEEP_EN = 1'h1;
    localparam logic [7:0]  RST_RAILS    = 8'h00;
    localparam logic [2:0]  HOLDOFF_FILL = 3'h7;

    // Fields from rail 8 down to rail 1.
    localparam logic [7:0][2:0] UP_SLOTS = {3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
    localparam logic [7:0][2:0] DN_SLOTS = {3'h3, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h1, 3'h1};
    localparam logic [7:0][2:0] SX_SLOTS = {3'h3, 3'h1, 3'h2, 3'h0, 3'h0, 3'h3, 3'h1, 3'h0};
    localparam logic [7:0][2:0] SE_SLOTS = {3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h0};
    localparam logic [2:0] UP_LAST = 3'h4;
    localparam logic [2:0] DN_LAST = 3'h3;
    localparam logic [2:0] SX_LAST = 3'h3;
    localparam logic [2:0] SE_LAST = 3'h3;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PWR_UP,
        ST_ACTIVE,
        ST_SLP_ENTRY,
        ST_SLEEP,
        ST_SLP_EXIT,
        ST_PWR_DOWN
    } rsc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rsc_apb_in_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rsc_apb_out_t;

    typedef struct packed {
        rsc_state_t  state;
        logic [2:0]  slot;
        logic [15:0] tick;
        logic [7:0]  rails;
        logic [2:0]  flags;
        logic [2:0]  mask;
        logic        sleep_en;
        logic [1:0]  act_s;
        logic [1:0]  slp_s;
        logic [1:0]  emr_s;
        logic [1:0]  rst_s;
        logic        emr_prev;
        logic        drive;
        logic [2:0]  holdoff;
        logic        irq_n;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rsc_regs_t;

endpackage

// file: logic/rsc_rail_sequence_controller.sv
// Purpose: Eight-rail power sequencer core with fault flags, interrupt and APB registers.
// Assumes: All input pins other than the APB group, clock and rst are asynchronous and are synchronised here.
// Notes:   The reset pin is open drain; the board pull-up makes its high level.
// How it works
// - Activate high starts power-up and leads to the active state.
// - Activate low starts power-down and leads to the shutdown state.
// - Interrupt output goes low while any enabled fault flag is set.
// - Reset pin seen low while not driven by us records a fault.
// - Every fault is latched into a flag register readable by software.
// - Flags persist until software writes one to them; interrupt follows them.
// - Sleep input low runs the sleep-entry sequence into the sleep state.
// - Sleep input high runs the sleep-exit sequence back to active.
// - Emergency input low forces power-down regardless of activate.
// - All four slot tables are fixed defaults, usable straight from reset.
// - Power-up slots: 1,2,7 then 3,4,8 then 5 then 6, 625 us apart.
// - Power-down slots: 1,2,6,7 then 5 then 3,4,8, 625 us apart.
// - Sleep exit slots: 2,7 then 6 then 3,8; rails 1,4,5 untouched.
// - Sleep entry slots: 6 then 3,8 then 2,7, 625 us apart.
// - Eight independent rail enable outputs, one per converter.
`timescale 1ns/10ps
module rsc_rail_sequence_controller #(
    parameter int SLOT_CYCLES = rsc_pkg::SLOT_CYC
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire rsc_pkg::rsc_apb_in_t  apb_in,
    output wire rsc_pkg::rsc_apb_out_t apb_out,
    input  wire logic                  activate_in,
    input  wire logic                  sleep_n,
    input  wire logic                  emergency_powerdown_n,
    input  wire logic                  sys_reset_n_in,
    output wire logic                  sys_reset_n_out,
    output wire logic                  sys_reset_n_oe_n,
    output wire logic [7:0]            rail_enable,
    output wire logic                  fault_irq_n
);

    rsc_pkg::rsc_regs_t     q;
    rsc_pkg::rsc_regs_t     d;
    logic                   acc;
    logic                   wr_done;
    logic                   mapped;
    logic [31:0]            rdata;
    logic [2:0]             clr;
    logic [2:0]             set;
    logic                   stop;
    logic                   in_seq;
    logic                   turn_on;
    logic [7:0][2:0]        tbl;
    logic [2:0]             last;
    rsc_pkg::rsc_state_t    target;
    logic [2:0]             slot_nx;
    logic [7:0]             hit;

    // Rails whose table entry names the given slot; slot 0 never matches a step.
    function automatic logic [7:0] slot_hits(input logic [7:0][2:0] t, input logic [2:0] s);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (t[i] == s) && (s != 3'h0);
        end
        return m;
    endfunction

    function automatic logic is_reg(input logic [7:0] a);
        return (a == rsc_pkg::OFS_FAULT_FLAGS_A) || (a == rsc_pkg::OFS_FAULT_MASK) ||
               (a == rsc_pkg::OFS_STATUS) || (a == rsc_pkg::OFS_CONTROL);
    endfunction

    always_comb begin
        d       = q;
        clr     = 3'h0;
        set     = 3'h0;
        rdata   = 32'h0;
        tbl     = rsc_pkg::UP_SLOTS;
        last    = rsc_pkg::UP_LAST;
        target  = rsc_pkg::ST_ACTIVE;
        in_seq  = 1'b0;
        turn_on = 1'b1;
        hit     = 8'h00;
        slot_nx = q.slot + 3'h1;

        // Only the second stage of each synchroniser is read below.
        d.act_s = {q.act_s[0], activate_in};
        d.slp_s = {q.slp_s[0], sleep_n};
        d.emr_s = {q.emr_s[0], emergency_powerdown_n};
        d.rst_s = {q.rst_s[0], sys_reset_n_in};
        d.emr_prev = q.emr_s[1];

        // One wait state: read data is captured in the first access cycle.
        acc     = apb_in.psel && apb_in.penable && !q.pready;
        wr_done = apb_in.psel && apb_in.penable && q.pready && apb_in.pwrite;
        mapped  = is_reg(apb_in.paddr);
        unique case (apb_in.paddr)
            rsc_pkg::OFS_FAULT_FLAGS_A: rdata[2:0] = q.flags;
            rsc_pkg::OFS_FAULT_MASK:    rdata[2:0] = q.mask;
            rsc_pkg::OFS_STATUS: begin
                rdata[rsc_pkg::STS_STATE_LSB +: 3] = q.state;
                rdata[rsc_pkg::STS_SLOT_LSB +: 3]  = q.slot;
                rdata[rsc_pkg::STS_RAILS_LSB +: 8] = q.rails;
                rdata[rsc_pkg::STS_DRIVE_BIT]      = q.drive;
            end
            rsc_pkg::OFS_CONTROL:       rdata[rsc_pkg::CTL_SLEEP_EN] = q.sleep_en;
            default:                    rdata = 32'h0;
        endcase
        d.pready  = acc;
        d.pslverr = acc && !mapped;
        if (acc) begin
            d.prdata = rdata;
        end
        if (wr_done && mapped) begin
            unique case (apb_in.paddr)
                rsc_pkg::OFS_FAULT_FLAGS_A: clr = apb_in.pwdata[2:0];
                rsc_pkg::OFS_FAULT_MASK:    d.mask = apb_in.pwdata[2:0];
                rsc_pkg::OFS_CONTROL:       d.sleep_en = apb_in.pwdata[rsc_pkg::CTL_SLEEP_EN];
                default:                    d.mask = q.mask;
            endcase
        end

        // Emergency low overrides activate in every state that holds rails up.
        stop = !q.emr_s[1] || !q.act_s[1];
        unique case (q.state)
            rsc_pkg::ST_OFF: begin
                if (q.act_s[1] && q.emr_s[1]) begin
                    d.state = rsc_pkg::ST_PWR_UP;
                end
            end
            rsc_pkg::ST_PWR_UP: begin
                if (stop) begin
                    d.state = rsc_pkg::ST_PWR_DOWN;
                    set[rsc_pkg::FLG_SEQ_ABORT] = 1'b1;
                end else begin
                    in_seq = 1'b1;
                end
            end
            rsc_pkg::ST_ACTIVE: begin
                if (stop) begin
                    d.state = rsc_pkg::ST_PWR_DOWN;
                end else if (!q.slp_s[1] && q.sleep_en) begin
                    d.state = rsc_pkg::ST_SLP_ENTRY;
                end
            end
            rsc_pkg::ST_SLP_ENTRY: begin
                if (stop) begin
                    d.state = rsc_pkg::ST_PWR_DOWN;
                end else begin
                    in_seq  = 1'b1;
                    tbl     = rsc_pkg::SE_SLOTS;
                    last    = rsc_pkg::SE_LAST;
                    target  = rsc_pkg::ST_SLEEP;
                    turn_on = 1'b0;
                end
            end
            rsc_pkg::ST_SLEEP: begin
                if (stop) begin
                    d.state = rsc_pkg::ST_PWR_DOWN;
                end else if (q.slp_s[1]) begin
                    d.state = rsc_pkg::ST_SLP_EXIT;
                end
            end
            rsc_pkg::ST_SLP_EXIT: begin
                if (stop) begin
                    d.state = rsc_pkg::ST_PWR_DOWN;
                end else begin
                    in_seq = 1'b1;
                    tbl    = rsc_pkg::SX_SLOTS;
                    last   = rsc_pkg::SX_LAST;
                end
            end
            rsc_pkg::ST_PWR_DOWN: begin
                in_seq  = 1'b1;
                tbl     = rsc_pkg::DN_SLOTS;
                last    = rsc_pkg::DN_LAST;
                target  = rsc_pkg::ST_OFF;
                turn_on = 1'b0;
            end
            default: d.state = rsc_pkg::ST_OFF;
        endcase

        // Leaving a state restarts the slot walk; the first slot lands one cycle later.
        if (d.state != q.state) begin
            d.slot = 3'h0;
            d.tick = 16'h0;
        end else if (in_seq) begin
            if (q.tick == 16'h0) begin
                hit     = slot_hits(tbl, slot_nx);
                d.rails = turn_on ? (q.rails | hit) : (q.rails & ~hit);
                d.slot  = slot_nx;
                d.tick  = 16'(SLOT_CYCLES - 1);
                if (slot_nx == last) begin
                    d.state = target;
                end
            end else begin
                d.tick = q.tick - 16'h1;
            end
        end

        // Reset is held low until power-up completes; the holdoff covers pin rise and sync delay.
        d.drive   = (d.state == rsc_pkg::ST_OFF) || (d.state == rsc_pkg::ST_PWR_UP) ||
                    (d.state == rsc_pkg::ST_PWR_DOWN);
        d.holdoff = q.drive ? rsc_pkg::HOLDOFF_FILL : {q.holdoff[1:0], 1'b0};
        if (!q.rst_s[1] && !q.drive && (q.holdoff == 3'h0)) begin
            set[rsc_pkg::FLG_EXT_RESET] = 1'b1;
        end
        if (q.emr_prev && !q.emr_s[1]) begin
            set[rsc_pkg::FLG_EMERGENCY] = 1'b1;
        end

        // A fault arriving with its own clear stays set.
        d.flags = (q.flags & ~clr) | set;
        d.irq_n = ~|(d.flags & d.mask);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q          <= '0;
            q.state    <= rsc_pkg::ST_OFF;
            q.rails    <= rsc_pkg::RST_RAILS;
            q.mask     <= rsc_pkg::RST_MASK;
            q.sleep_en <= rsc_pkg::RST_SLEEP_EN;
            q.drive    <= 1'b1;
            q.holdoff  <= rsc_pkg::HOLDOFF_FILL;
            q.irq_n    <= 1'b1;
            q.act_s    <= 2'h0;
            q.slp_s    <= 2'h3;
            q.emr_s    <= 2'h3;
            q.rst_s    <= 2'h3;
            q.emr_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign apb_out.pready    = q.pready;
    assign apb_out.pslverr   = q.pslverr;
    assign apb_out.prdata    = q.prdata;
    assign rail_enable       = q.rails;
    assign fault_irq_n       = q.irq_n;
    assign sys_reset_n_out   = 1'b0;
    assign sys_reset_n_oe_n  = !q.drive;

    chk_irq_follows: assert property (@(posedge clock) disable iff (rst)
        ((set & q.mask) != 3'h0 && !(wr_done && apb_in.paddr == rsc_pkg::OFS_FAULT_MASK))
        |=> fault_irq_n == 1'b0)
        else $error("enabled fault did not pull the interrupt low");

    chk_flag_sticky: assert property (@(posedge clock) disable iff (rst)
        (clr == 3'h0) |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
        else $error("fault flag dropped without a clearing write");

    chk_ext_reset_flag: assert property (@(posedge clock) disable iff (rst)
        (!q.rst_s[1] && !q.drive && q.holdoff == 3'h0) |=> q.flags[rsc_pkg::FLG_EXT_RESET])
        else $error("external reset pull-down not recorded");

    chk_power_up_start: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_OFF && q.act_s[1] && q.emr_s[1]) |=> q.state == rsc_pkg::ST_PWR_UP)
        else $error("activate high did not start power-up");

    chk_power_down_start: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_ACTIVE && !q.act_s[1]) |=> q.state == rsc_pkg::ST_PWR_DOWN)
        else $error("activate low did not start power-down");

    chk_emergency_down: assert property (@(posedge clock) disable iff (rst)
        (!q.emr_s[1] && q.state != rsc_pkg::ST_OFF && q.state != rsc_pkg::ST_PWR_DOWN)
        |=> q.state == rsc_pkg::ST_PWR_DOWN)
        else $error("emergency input did not force power-down");

    chk_sleep_entry: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_ACTIVE && q.act_s[1] && q.emr_s[1] && !q.slp_s[1] && q.sleep_en)
        |=> q.state == rsc_pkg::ST_SLP_ENTRY)
        else $error("sleep low did not start sleep entry");

    chk_sleep_exit: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_SLEEP && q.act_s[1] && q.emr_s[1] && q.slp_s[1])
        |=> q.state == rsc_pkg::ST_SLP_EXIT)
        else $error("sleep high did not start sleep exit");

    chk_slot_hold: assert property (@(posedge clock) disable iff (rst)
        (q.tick != 16'h0 && q.state == $past(q.state)) |=> (q.slot == $past(q.slot)) || (q.state != $past(q.state)))
        else $error("slot advanced before its interval expired");

    chk_up_complete: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_ACTIVE && $past(q.state) == rsc_pkg::ST_PWR_UP) |-> q.rails == 8'hff)
        else $error("power-up finished with a rail still off");

    chk_down_complete: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_OFF && $past(q.state) == rsc_pkg::ST_PWR_DOWN) |-> q.rails == 8'h00)
        else $error("power-down finished with a rail still on");

    chk_sleep_rails: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_SLEEP && $past(q.state) == rsc_pkg::ST_SLP_ENTRY)
        |-> (q.rails & 8'he6) == 8'h00)
        else $error("sleep entry left a sleep rail on");

    chk_slot0_still: assert property (@(posedge clock) disable iff (rst)
        ($past(q.state) == rsc_pkg::ST_SLP_ENTRY || $past(q.state) == rsc_pkg::ST_SLP_EXIT)
        && (q.state != rsc_pkg::ST_PWR_DOWN) |-> (q.rails & 8'h19) == ($past(q.rails) & 8'h19))
        else $error("slot-0 rail changed during a sleep sequence");

    chk_exit_rails: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_ACTIVE && $past(q.state) == rsc_pkg::ST_SLP_EXIT)
        |-> (q.rails & 8'he6) == 8'he6)
        else $error("sleep exit finished with a sleep rail off");

    // Rail changes stay inside sequences and keep each sequence's direction, slots step by one, and only the first power-up slot is held to its pattern.
    chk_rails_in_seq: assert property (@(posedge clock) disable iff (rst)
        (q.rails != $past(q.rails))
        |-> !($past(q.state) inside {rsc_pkg::ST_OFF, rsc_pkg::ST_ACTIVE, rsc_pkg::ST_SLEEP}))
        else $error("rails changed outside a sequence");

    chk_up_only_on: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_PWR_UP || q.state == rsc_pkg::ST_SLP_EXIT)
        |=> (q.rails & $past(q.rails)) == $past(q.rails))
        else $error("a rail turned off during a rising sequence");

    chk_down_only_off: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_PWR_DOWN || q.state == rsc_pkg::ST_SLP_ENTRY)
        |=> (q.rails & ~$past(q.rails)) == 8'h00)
        else $error("a rail turned on during a falling sequence");

    chk_first_slot: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_PWR_UP && q.slot == 3'h0 && q.act_s[1] && q.emr_s[1])
        |=> q.rails == ($past(q.rails) | 8'h43) && q.slot == 3'h1)
        else $error("first power-up slot did not raise rails 1, 2 and 7");

    chk_slot_step: assert property (@(posedge clock) disable iff (rst)
        (in_seq && q.tick == 16'h0)
        |=> q.slot == $past(q.slot) + 3'h1)
        else $error("slot did not step when its interval expired");

    chk_drive_states: assert property (@(posedge clock) disable iff (rst)
        sys_reset_n_oe_n == !(q.state inside {rsc_pkg::ST_OFF, rsc_pkg::ST_PWR_UP, rsc_pkg::ST_PWR_DOWN}))
        else $error("reset pin drive does not match the state");

    chk_no_self_fault: assert property (@(posedge clock) disable iff (rst)
        (q.drive && !q.flags[rsc_pkg::FLG_EXT_RESET]) |=> !q.flags[rsc_pkg::FLG_EXT_RESET])
        else $error("own reset drive recorded as an external fault");

    chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
        (wr_done && apb_in.paddr == rsc_pkg::OFS_FAULT_FLAGS_A)
        |=> (q.flags & $past(apb_in.pwdata[2:0]) & ~$past(set)) == 3'h0)
        else $error("written one did not clear its flag");

    chk_set_wins: assert property (@(posedge clock) disable iff (rst)
        (set != 3'h0) |=> (q.flags & $past(set)) == $past(set))
        else $error("fault event lost against a clear");

    chk_emergency_flag: assert property (@(posedge clock) disable iff (rst)
        (q.emr_prev && !q.emr_s[1]) |=> q.flags[rsc_pkg::FLG_EMERGENCY])
        else $error("emergency fall not recorded");

    chk_abort_flag: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_PWR_UP && !q.act_s[1])
        |=> q.flags[rsc_pkg::FLG_SEQ_ABORT] && q.state == rsc_pkg::ST_PWR_DOWN)
        else $error("aborted power-up not recorded");

    chk_pready_pulse: assert property (@(posedge clock) disable iff (rst)
        apb_out.pready |=> !apb_out.pready)
        else $error("ready stood longer than one cycle");

    chk_sleep_ignored: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_ACTIVE && !q.sleep_en && q.act_s[1] && q.emr_s[1])
        |=> q.state == rsc_pkg::ST_ACTIVE)
        else $error("sleep entered while sleep is disabled");

    chk_off_holds: assert property (@(posedge clock) disable iff (rst)
        (q.state == rsc_pkg::ST_OFF && !(q.act_s[1] && q.emr_s[1])) |=> q.state == rsc_pkg::ST_OFF)
        else $error("power-up started without activate or under emergency");

endmodule

// file: bench/rsc_far_side.sv
// Purpose: Far side of the sequencer: safety controller, SoC and the open-drain reset wire.
// Assumes: Commands come from the bench; pin changes follow after a chosen lag of clock cycles.
// Notes:   The reset wire has a board pull-up, so it reads high unless someone pulls it low.
`timescale 1ns/10ps
module rsc_far_side (
    input  wire logic       clock,
    input  wire logic [2:0] cmd,
    input  wire logic [3:0] lag,
    input  wire logic       pull_low,
    input  wire logic       sys_reset_n_out,
    input  wire logic       sys_reset_n_oe_n,
    output wire logic       activate_in,
    output wire logic       sleep_n,
    output wire logic       emergency_powerdown_n,
    output wire logic       sys_reset_n_in
);
    logic [3:0] wait_q = 4'h0;
    logic [2:0] pins_q = 3'h3;

    assign {activate_in, sleep_n, emergency_powerdown_n} = pins_q;

    // A slow controller lets a new command settle for lag cycles before it reaches the pins.
    always @(posedge clock) begin
        if (pins_q === cmd) begin
            wait_q <= 4'h0;
        end else if (wait_q >= lag) begin
            pins_q <= cmd;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end

    assign sys_reset_n_in = !((sys_reset_n_oe_n == 1'b0 && sys_reset_n_out == 1'b0) || pull_low);
endmodule

// file: bench/testbench.sv
// Purpose: Self-checking bench of the rail sequence controller.
// Assumes: Slot time shortened to a few cycles; expected rail patterns are built from the slot order.
// Notes:   Random pin lag and random interrupt masks come from a fixed seed.
`timescale 1ns/10ps
module testbench;
    localparam int SLOT_N = 4;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    rsc_pkg::rsc_apb_in_t  apb_in = '0;
    rsc_pkg::rsc_apb_out_t apb_out;
    logic [2:0]            cmd = 3'h3;
    logic [3:0]            lag = 4'h0;
    logic                  pull = 1'b0;
    logic                  act, slp_n, emr_n, rst_in, rst_out, rst_oe_n, irq_n;
    logic [7:0]            rails;
    int                    miscompares = 0;
    int                    total_checks = 0;

    always #20 clock = ~clock;

    rsc_rail_sequence_controller #(.SLOT_CYCLES(SLOT_N)) i_rsc_rail_sequence_controller (
        .clock(clock), .rst(rst), .apb_in(apb_in), .apb_out(apb_out), .activate_in(act),
        .sleep_n(slp_n), .emergency_powerdown_n(emr_n), .sys_reset_n_in(rst_in),
        .sys_reset_n_out(rst_out), .sys_reset_n_oe_n(rst_oe_n), .rail_enable(rails), .fault_irq_n(irq_n));

    rsc_far_side i_rsc_far_side (
        .clock(clock), .cmd(cmd), .lag(lag), .pull_low(pull), .sys_reset_n_out(rst_out),
        .sys_reset_n_oe_n(rst_oe_n), .activate_in(act), .sleep_n(slp_n),
        .emergency_powerdown_n(emr_n), .sys_reset_n_in(rst_in));

    task automatic report_and_stop;
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    // Entered just after a rising edge; the idle edge at the end keeps two requests from colliding.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        apb_in <= {1'b1, 1'b0, wr, addr, wd};
        @(posedge clock);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in <= '0;
        @(posedge clock);
    endtask

    // Each slot must bring exactly its pattern, and consecutive slots exactly SLOT_N cycles apart.
    task automatic run_seq(input logic [7:0] m0, m1, m2, m3, input int n);
        logic [7:0] exp [4];
        logic [7:0] prev;
        int         gap;
        exp = '{m0, m1, m2, m3};
        prev = rails;
        for (int i = 0; i < n; i++) begin
            gap = 0;
            do begin
                @(posedge clock);
                gap++;
            end while (rails === prev && gap < 200);
            check("rail pattern", rails, exp[i]);
            if (i > 0) check("slot spacing", gap, SLOT_N);
            prev = rails;
        end
    endtask

    // About four hundred cycles are needed; twenty thousand leaves room for every bounded wait.
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        report_and_stop;
    end

    initial begin
        logic [31:0] d;
        logic        e;
        logic [2:0]  m;
        d = $urandom(32'h7bef);
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("rails after reset", rails, 8'h00);
        check("irq after reset", irq_n, 1'b1);
        check("reset pin driven", rst_oe_n, 1'b0);
        check("reset pin level", rst_out, 1'b0);
        apb(1'b0, rsc_pkg::OFS_FAULT_MASK, 32'h0, d, e);
        check("mask reset", d, 32'h7);
        apb(1'b0, 8'h10, 32'h0, d, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", d, 32'h0);
        lag <= 4'($urandom_range(0, 7));
        cmd <= 3'h7;
        run_seq(8'h43, 8'hcf, 8'hdf, 8'hff, 4);
        apb(1'b0, rsc_pkg::OFS_STATUS, 32'h0, d, e);
        check("state active", d[2:0], rsc_pkg::ST_ACTIVE);
        check("reset released", rst_oe_n, 1'b1);
        cmd <= 3'h5;
        run_seq(8'hdf, 8'h5b, 8'h19, 8'h00, 3);
        apb(1'b0, rsc_pkg::OFS_STATUS, 32'h0, d, e);
        check("state sleep", d[2:0], rsc_pkg::ST_SLEEP);
        lag <= 4'($urandom_range(0, 7));
        cmd <= 3'h7;
        run_seq(8'h5b, 8'h7b, 8'hff, 8'h00, 3);
        apb(1'b1, rsc_pkg::OFS_CONTROL, 32'h0, d, e);
        cmd <= 3'h5;
        repeat (20) @(posedge clock);
        apb(1'b0, rsc_pkg::OFS_STATUS, 32'h0, d, e);
        check("sleep ignored", d[2:0], rsc_pkg::ST_ACTIVE);
        check("status rails", d[15:8], 8'hff);
        cmd <= 3'h7;
        repeat (20) @(posedge clock);
        apb(1'b1, rsc_pkg::OFS_CONTROL, 32'h1, d, e);
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 3'h0 : 3'($urandom);
            apb(1'b1, rsc_pkg::OFS_FAULT_MASK, {29'h0, m}, d, e);
            pull <= 1'b1;
            repeat (4) @(posedge clock);
            pull <= 1'b0;
            repeat (4) @(posedge clock);
            check("irq on pull", irq_n, !m[0]);
            apb(1'b1, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h0, d, e);
            apb(1'b0, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h0, d, e);
            check("flags kept", d, 32'h1);
            apb(1'b1, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h1, d, e);
            repeat (2) @(posedge clock);
            check("irq cleared", irq_n, 1'b1);
        end
        apb(1'b1, rsc_pkg::OFS_FAULT_MASK, 32'h7, d, e);
        cmd <= 3'h3;
        run_seq(8'h9c, 8'h8c, 8'h00, 8'h00, 3);
        cmd <= 3'h7;
        run_seq(8'h43, 8'hcf, 8'hdf, 8'hff, 4);
        lag <= 4'($urandom_range(0, 7));
        cmd <= 3'h6;
        run_seq(8'h9c, 8'h8c, 8'h00, 8'h00, 3);
        check("irq on emergency", irq_n, 1'b0);
        apb(1'b0, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h0, d, e);
        check("emergency flag", d, 32'h2);
        apb(1'b1, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h7, d, e);
        lag <= 4'h0;
        cmd <= 3'h7;
        run_seq(8'h43, 8'h43, 8'h43, 8'h43, 1);
        cmd <= 3'h3;
        repeat (40) @(posedge clock);
        check("rails after abort", rails, 8'h00);
        check("irq on abort", irq_n, 1'b0);
        apb(1'b0, rsc_pkg::OFS_FAULT_FLAGS_A, 32'h0, d, e);
        check("abort flag", d, 32'h4);
        report_and_stop;
    end
endmodule
